// *** common/rtcf_pkg.sv ***
// constants and types for the rtc event flag and date alarm block
// Contract
// - status bit 7 reads one when any enabled event flag in bits 6:4 is set.
// - each status read returns current flags, then clears bit 7 and bits 6:4; an event arriving in the read's own cycle still sets its flag.
// - periodic tick sets bit 6, held until the next status read.
// - qualified alarm match sets bit 5, held until the next status read.
// - finished counter update sets bit 4, held until the next status read.
// - event flags record regardless of enables; enables mask only bit 7 and interrupt.
// - after update flag, counters stay unchanged for over 999 ms.
// - non-zero date alarm field must equal month counter for an alarm.
// - zero date alarm field is don't-care, left out of the comparison.
// - mode bits 6, 5, 4 enable periodic, alarm, update events as interrupts.
// - counters update once per second unless inhibited; one update event each.
package rtcf_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned UPDATE_INTERVAL_MS = 1000;
  localparam int unsigned UPDATE_CYCLES      = (UPDATE_INTERVAL_MS * 1000000) / CLK_PERIOD_NS;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EV_NUM = 3;
  localparam int unsigned DATE_W = 6;
  localparam int unsigned CNT_W  = 32;

  // printed offsets are register indices; byte address is four times
  localparam logic [5:0] IDX_MODE   = 6'h0b;
  localparam logic [5:0] IDX_STATUS = 6'h0c;
  localparam logic [5:0] IDX_DATE   = 6'h0d;

  localparam int unsigned BIT_REQ     = 7;
  localparam int unsigned BIT_INHIBIT = 7;
  localparam int unsigned EN_LO       = 4;
  localparam int unsigned EN_HI       = 6;
  localparam int unsigned FLAG_LO     = 4;

  localparam int unsigned EV_UPD = 0;
  localparam int unsigned EV_ALM = 1;
  localparam int unsigned EV_PER = 2;

  localparam logic [3:0]        MODE_RST = 4'h0;
  localparam logic [DATE_W-1:0] DATE_RST = 6'h00;
  localparam logic [DATE_W-1:0] DATE_ANY = 6'h00;
  localparam logic [3:0]        RSVD_LO  = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } rtcf_wr_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rtcf_rd_t;

endpackage

// *** common/rtcf_upd_if.sv ***
// carrier between the block and its one-second update timer
`timescale 1ns/1ns
interface rtcf_upd_if;
  logic inhibit;
  logic update;
  modport timer (input inhibit, output update);
  modport ctrl  (output inhibit, input update);
endinterface

// *** core/rtcf_evt_flag.sv ***
// one sticky event flag, cleared by a status read
`timescale 1ns/1ns
module rtcf_evt_flag (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= (flag & ~clr) | set;
    end
  end

endmodule

// *** core/rtcf_upd_timer.sv ***
// one-second update pacing for the time and date counters
`timescale 1ns/1ns
module rtcf_upd_timer #(
  parameter int unsigned PERIOD = rtcf_pkg::UPDATE_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst,
  rtcf_upd_if.timer   upd
);

  localparam logic [rtcf_pkg::CNT_W-1:0] LAST = rtcf_pkg::CNT_W'(PERIOD - 1);

  logic [rtcf_pkg::CNT_W-1:0] cnt;

  // restart on inhibit so the first update after release is a full period out
  always_ff @(posedge clk) begin
    if (rst || upd.inhibit) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      upd.update <= 1'b0;
    end else begin
      upd.update <= ~upd.inhibit & (cnt == LAST);
    end
  end

endmodule

// *** core/rtcf_top.sv ***
// rtc event status, date alarm qualification and axi4-lite register slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module rtcf_top #(
  parameter int unsigned UPDATE_PERIOD = rtcf_pkg::UPDATE_CYCLES
) (
  input  wire logic                          CLK,
  input  wire logic                          SYS_RST,
  input  wire logic                          PERIODIC_TICK,
  input  wire logic                          ALARM_MATCH,
  input  wire logic [rtcf_pkg::DATE_W-1:0]   MONTH,
  output logic                               UPDATE_STROBE,
  output logic                               IRQ,
  input  wire logic [rtcf_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic [2:0]                    S_AXI_AWPROT,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [rtcf_pkg::DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [rtcf_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic [2:0]                    S_AXI_ARPROT,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [rtcf_pkg::DATA_W-1:0]        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY
);

  localparam int unsigned EV_NUM = rtcf_pkg::EV_NUM;
  localparam int unsigned DATE_W = rtcf_pkg::DATE_W;
  localparam int unsigned DATA_W = rtcf_pkg::DATA_W;

  // software-visible state
  logic [3:0]        mode;
  logic [DATE_W-1:0] date_match;
  logic [EV_NUM-1:0] flags;
  logic [EV_NUM-1:0] ev_set;
  logic              status_clr;
  logic              req_now;
  logic [7:0]        status_byte;
  logic [EV_NUM-1:0] enables;
  logic              inhibit;

  // event sources
  logic              upd_done;
  logic              date_ok;
  logic              alarm_ev;

  // write channel
  rtcf_pkg::rtcf_wr_t          wr_state;
  rtcf_pkg::rtcf_wr_t          next_wr_state;
  logic                        aw_held;
  logic                        next_aw_held;
  logic                        w_held;
  logic                        next_w_held;
  logic [rtcf_pkg::ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0]           w_data;
  logic [3:0]                  w_strb;
  logic                        aw_hs;
  logic                        w_hs;
  logic                        do_write;
  logic [5:0]                  wr_idx;
  logic                        wr_hit;

  // read channel
  rtcf_pkg::rtcf_rd_t rd_state;
  logic               ar_hs;
  logic [5:0]         rd_idx;
  logic [7:0]         rd_byte;
  logic               rd_hit;

  rtcf_upd_if upd ();

  assign enables = mode[rtcf_pkg::EN_HI-rtcf_pkg::EN_LO:0];
  assign inhibit = mode[rtcf_pkg::BIT_INHIBIT-rtcf_pkg::EN_LO];

  // pacing of the counter updates
  assign upd.inhibit = inhibit;

  rtcf_upd_timer #(
    .PERIOD (UPDATE_PERIOD)
  ) u_timer (
    .clk (CLK),
    .rst (SYS_RST),
    .upd (upd)
  );

  // strobe to the counters, then the completion one cycle later
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      UPDATE_STROBE <= 1'b0;
    end else begin
      UPDATE_STROBE <= upd.update;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      upd_done <= 1'b0;
    end else begin
      upd_done <= UPDATE_STROBE;
    end
  end

  // date alarm qualification
  always_comb begin
    if (date_match == rtcf_pkg::DATE_ANY) begin
      date_ok = 1'b1;
    end else begin
      date_ok = (date_match == MONTH);
    end
  end

  assign alarm_ev = ALARM_MATCH & date_ok;

  // flags take their events whatever the enables say
  always_comb begin
    ev_set                   = '0;
    ev_set[rtcf_pkg::EV_PER] = PERIODIC_TICK;
    ev_set[rtcf_pkg::EV_ALM] = alarm_ev;
    ev_set[rtcf_pkg::EV_UPD] = upd_done;
  end

  genvar gi;
  generate
    for (gi = 0; gi < EV_NUM; gi++) begin : g_flag
      rtcf_evt_flag u_flag (
        .clk  (CLK),
        .rst  (SYS_RST),
        .set  (ev_set[gi]),
        .clr  (status_clr),
        .flag (flags[gi])
      );
    end
  endgenerate

  assign req_now     = |(flags & enables);
  assign status_byte = {req_now, flags, rtcf_pkg::RSVD_LO};

  // interrupt is a level that tracks the combined request
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= req_now;
    end
  end

  // write path: address and data accepted in either order
  assign aw_hs    = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_hs     = S_AXI_WVALID & S_AXI_WREADY;
  assign do_write = aw_held & w_held & (wr_state == rtcf_pkg::WR_IDLE);
  assign wr_idx   = aw_addr[7:2];

  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_wr_state = wr_state;
    if (aw_hs) begin
      next_aw_held = 1'b1;
    end
    if (w_hs) begin
      next_w_held = 1'b1;
    end
    unique case (wr_state)
      rtcf_pkg::WR_IDLE: begin
        if (do_write) begin
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = rtcf_pkg::WR_RESP;
        end
      end
      rtcf_pkg::WR_RESP: begin
        if (S_AXI_BREADY) begin
          next_wr_state = rtcf_pkg::WR_IDLE;
        end
      end
      default: begin
        next_wr_state = rtcf_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_state      <= rtcf_pkg::WR_IDLE;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      wr_state      <= next_wr_state;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      // one write under way: hold off a second address or data beat
      S_AXI_AWREADY <= ~next_aw_held & (next_wr_state == rtcf_pkg::WR_IDLE);
      S_AXI_WREADY  <= ~next_w_held & (next_wr_state == rtcf_pkg::WR_IDLE);
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (aw_hs) begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
    end
  end

  assign wr_hit = (wr_idx == rtcf_pkg::IDX_MODE) | (wr_idx == rtcf_pkg::IDX_STATUS) |
                  (wr_idx == rtcf_pkg::IDX_DATE);

  // register writes; status is read-only and a write there does nothing
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode <= rtcf_pkg::MODE_RST;
    end else if (do_write && w_strb[0] && wr_idx == rtcf_pkg::IDX_MODE) begin
      mode <= w_data[rtcf_pkg::BIT_INHIBIT:rtcf_pkg::EN_LO];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      date_match <= rtcf_pkg::DATE_RST;
    end else if (do_write && w_strb[0] && wr_idx == rtcf_pkg::IDX_DATE) begin
      date_match <= w_data[DATE_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= rtcf_pkg::RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? rtcf_pkg::RESP_OKAY : rtcf_pkg::RESP_DECERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // read path: data registered one cycle after the address is taken
  assign ar_hs      = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_idx     = S_AXI_ARADDR[7:2];
  assign status_clr = ar_hs & (rd_idx == rtcf_pkg::IDX_STATUS);

  always_comb begin
    rd_byte = '0;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      rtcf_pkg::IDX_MODE: begin
        rd_byte = {mode, rtcf_pkg::RSVD_LO};
      end
      rtcf_pkg::IDX_STATUS: begin
        rd_byte = status_byte;
      end
      rtcf_pkg::IDX_DATE: begin
        rd_byte = {2'h0, date_match};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_state      <= rtcf_pkg::RD_IDLE;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= rtcf_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state)
        rtcf_pkg::RD_IDLE: begin
          S_AXI_ARREADY <= ~ar_hs;
          if (ar_hs) begin
            rd_state     <= rtcf_pkg::RD_DATA;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h000000, rd_byte};
            S_AXI_RRESP  <= rd_hit ? rtcf_pkg::RESP_OKAY : rtcf_pkg::RESP_DECERR;
          end
        end
        rtcf_pkg::RD_DATA: begin
          if (S_AXI_RREADY) begin
            rd_state      <= rtcf_pkg::RD_IDLE;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
          end
        end
        default: begin
          rd_state      <= rtcf_pkg::RD_IDLE;
          S_AXI_ARREADY <= 1'b0;
          S_AXI_RVALID  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** tb/rtcf_checker.sv ***
// port assertions for the rtc event flag block
`timescale 1ns/1ns
module rtcf_checker #(
  parameter int unsigned UPDATE_PERIOD = 50
) (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        PERIODIC_TICK,
  input wire logic        ALARM_MATCH,
  input wire logic        UPDATE_STROBE,
  input wire logic        IRQ,
  input wire logic        S_AXI_BVALID,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID
);
  logic        ar_hs;
  logic        st_rd;
  logic        dt_rd;
  logic        seen;
  logic [31:0] gap;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  // gap counts cycles since the last counter update
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_rd <= 1'b0;
      dt_rd <= 1'b0;
      seen  <= 1'b0;
      gap   <= 32'h0;
    end else begin
      if (ar_hs) st_rd <= (S_AXI_ARADDR == 8'h30);
      if (ar_hs) dt_rd <= (S_AXI_ARADDR == 8'h34);
      if (UPDATE_STROBE) seen <= 1'b1;
      gap <= UPDATE_STROBE ? 32'h1 : gap + 32'h1;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  req_clear_a: assert property (ar_hs && S_AXI_ARADDR == 8'h30 && !PERIODIC_TICK && !ALARM_MATCH
    && !$past(UPDATE_STROBE) |-> ##2 !IRQ) else $error("irq left after clearing read");
  read_lat_a: assert property (ar_hs |=> S_AXI_RVALID) else $error("read answer late");
  read_okay_a: assert property (ar_hs && S_AXI_ARADDR inside {8'h2c, 8'h30, 8'h34}
    |=> S_AXI_RRESP == rtcf_pkg::RESP_OKAY) else $error("mapped read refused");
  rsvd_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0
    && (dt_rd ? S_AXI_RDATA[7:6] == 2'h0 : S_AXI_RDATA[3:0] == 4'h0)) else $error("reserved bits set");
  req_bit_a: assert property (S_AXI_RVALID && st_rd && S_AXI_RDATA[7] |-> S_AXI_RDATA[6:4] != 3'h0)
    else $error("request bit without flag");
  irq_drop_a: assert property ($fell(IRQ) |-> $past(st_rd && S_AXI_RVALID) || $past(S_AXI_BVALID))
    else $error("irq dropped without cause");
  upd_gap_a: assert property (UPDATE_STROBE && seen |-> gap >= UPDATE_PERIOD)
    else $error("updates too close");
  decerr_a: assert property (ar_hs && !(S_AXI_ARADDR inside {8'h2c, 8'h30, 8'h34})
    |=> S_AXI_RRESP == rtcf_pkg::RESP_DECERR && S_AXI_RDATA == 32'h0) else $error("unmapped read");
  cover property (ar_hs && S_AXI_ARADDR == 8'h30);
  cover property (UPDATE_STROBE && seen);
  cover property ($fell(IRQ));
endmodule

bind rtcf_top rtcf_checker #(.UPDATE_PERIOD(UPDATE_PERIOD)) chk (
  .CLK, .SYS_RST, .PERIODIC_TICK, .ALARM_MATCH, .UPDATE_STROBE, .IRQ, .S_AXI_BVALID,
  .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID
);

// *** tb/testbench.sv ***
// self-checking bench for the rtc event flag block
`timescale 1ns/1ns
module testbench;
  localparam int unsigned PER = 60;
  logic        clk = 1'b0, rst = 1'b1, tick = 1'b0, alm = 1'b0, wbusy = 1'b0, irq_exp = 1'b0, u_d = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ustb, irq, awready, wready, bvalid, arready, rvalid;
  logic [5:0]  mon = 6'h00, m_date, d;
  logic [3:0]  wstrb = 4'h0, m_mode;
  logic [2:0]  fl;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];
  int          miscompares = 0, n_tests = 0, n_upd = 0, n0;

  rtcf_top #(.UPDATE_PERIOD(PER)) dut (
    .CLK(clk), .SYS_RST(rst), .PERIODIC_TICK(tick), .ALARM_MATCH(alm), .MONTH(mon),
    .UPDATE_STROBE(ustb), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready)
  );

  always #20 clk = ~clk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // model; irq is only compared once a mode write has settled
  always @(posedge clk) begin
    if (rst) begin
      fl = 3'h0;
      irq_exp = 1'b0;
      u_d = 1'b0;
    end else begin
      if (!wbusy) chk({33'h0, irq}, {33'h0, irq_exp}, "irq");
      irq_exp = |(fl & m_mode[2:0]);
      if (arvalid && arready) begin
        case (araddr)
          8'h2c: exp_q.push_back({2'h0, 24'h0, m_mode, 4'h0});
          8'h30: exp_q.push_back({2'h0, 24'h0, |(fl & m_mode[2:0]), fl, 4'h0});
          8'h34: exp_q.push_back({2'h0, 26'h0, m_date});
          default: exp_q.push_back({2'h3, 32'h0});
        endcase
        if (araddr == 8'h30) fl = 3'h0;
      end
      if (tick) fl[2] = 1'b1;
      if (alm && (m_date == 6'h00 || m_date == mon)) fl[1] = 1'b1;
      // completion flag lands one edge after the strobe to the counters
      if (u_d) fl[0] = 1'b1;
      u_d = ustb;
      if (ustb) n_upd++;
    end
  end

  task automatic ev(input logic p, input logic m);
    tick <= p;
    alm <= m;
    @(posedge clk);
    tick <= 1'b0;
    alm <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic s);
    logic       a_ok;
    logic       w_ok;
    logic [1:0] e;
    a_ok = 1'b0;
    w_ok = 1'b0;
    e = (a inside {8'h2c, 8'h30, 8'h34}) ? 2'h0 : 2'h3;
    wbusy <= 1'b1;
    awaddr <= a;
    wdata <= {24'($urandom), v};
    wstrb <= {3'($urandom), s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) a_ok = 1'b1;
      if (awready) awvalid <= 1'b0;
      if (wready) w_ok = 1'b1;
      if (wready) wvalid <= 1'b0;
    end while (!(a_ok && w_ok));
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk({bresp, 32'h0}, {e, 32'h0}, "bresp");
    if (s && a == 8'h2c) m_mode <= v[7:4];
    if (s && a == 8'h34) m_date <= v[5:0];
    @(posedge clk);
    wbusy <= 1'b0;
  endtask

  // p raises a periodic tick exactly at the address handshake
  task automatic rd(input logic [7:0] a, input logic p);
    araddr <= a;
    arvalid <= 1'b1;
    tick <= p;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    tick <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk({rresp, rdata}, exp_q.pop_front(), "read");
  endtask

  task automatic reset_and_read;
    rst <= 1'b1;
    m_mode <= 4'h0;
    m_date <= 6'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 3; k++) rd(8'(8'h2c + 4 * k), 1'b0);
    $display("reset values done");
  endtask

  // about 620 cycles expected; a hang runs into this
  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end

  initial begin
    void'($urandom(52));
    reset_and_read();
    wr(8'h2c, 8'h80, 1'b1);
    ev(1'b1, 1'b0);
    rd(8'h30, 1'b0);
    rd(8'h30, 1'b0);
    ev(1'b0, 1'b1);
    rd(8'h30, 1'b0);
    $display("masked flags done");
    repeat (12) begin
      d = 6'($urandom_range(1, 63));
      wr(8'h34, {2'h0, d}, 1'b1);
      mon <= $urandom_range(0, 1) ? d : 6'($urandom);
      ev(1'b0, 1'b1);
      rd(8'h30, 1'b0);
    end
    $display("date alarm done");
    wr(8'h34, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(8'h2c, {1'b1, 3'(i), 4'h0}, 1'b1);
      ev(1'($urandom), 1'($urandom));
      rd(8'h30, 1'($urandom));
      rd(8'h30, 1'b0);
    end
    $display("enables done");
    n0 = n_upd;
    repeat (150) @(posedge clk);
    chk(34'(n_upd - n0), 34'h0, "inhibited");
    wr(8'h2c, 8'h10, 1'b1);
    n0 = n_upd;
    repeat (200) @(posedge clk);
    chk(34'(n_upd - n0), 34'h3, "updates");
    rd(8'h30, 1'b0);
    $display("updates done");
    wr(8'h34, 8'h2a, 1'b0);
    wr(8'h30, 8'hff, 1'b1);
    wr(8'h38, 8'h11, 1'b1);
    rd(8'h34, 1'b0);
    rd(8'h38, 1'b0);
    rd(8'h00, 1'b0);
    wr(8'h34, 8'h15, 1'b1);
    rd(8'h34, 1'b0);
    $display("register access done");
    reset_and_read();
    wrap_up();
  end
endmodule
